/* common/ddr2_cfg_pkg.sv */
// Constants and carriers for the DDR2 configuration-word decoder
package ddr2_cfg_pkg;
  // ---------------------------------------------------------------
  // Load command carrier
  // ---------------------------------------------------------------
  localparam int OP_W = 14;
  localparam int COL_W = 10;
  typedef struct packed {
    logic [2:0] bank;
    logic [OP_W-1:0] op;
  } load_cmd_t;
  // Posted command held through additive latency
  typedef struct packed {
    logic valid;
    logic write;
    logic [COL_W-1:0] col;
  } posted_t;
  localparam logic [2:0] BANK_MAIN = 3'h0;
  localparam logic [2:0] BANK_EXT = 3'h1;
  // ---------------------------------------------------------------
  // Main word fields
  // ---------------------------------------------------------------
  localparam int M_BL_LO = 0;
  localparam int M_BL_HI = 2;
  localparam int M_BT = 3;
  localparam int M_CL_LO = 4;
  localparam int M_CL_HI = 6;
  localparam int M_TEST = 7;
  localparam int M_DLL_RST = 8;
  localparam int M_WR_LO = 9;
  localparam int M_WR_HI = 11;
  localparam int M_PD = 12;
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] CL_MIN = 3'h3;
  localparam logic [2:0] CL_MAX = 3'h7;
  localparam logic [2:0] WR_CODE_MIN = 3'h1;
  localparam logic [2:0] WR_CODE_MAX = 3'h6;
  // ---------------------------------------------------------------
  // Extended word fields
  // ---------------------------------------------------------------
  localparam int E_DLL_DIS = 0;
  localparam int E_DRV = 1;
  localparam int E_AL_LO = 3;
  localparam int E_AL_HI = 5;
  localparam int E_STB_DIS = 10;
  localparam int E_RSTB = 11;
  localparam logic [2:0] AL_MAX = 3'h6;
  // ---------------------------------------------------------------
  // Timing and depths
  // ---------------------------------------------------------------
  localparam logic [7:0] DLL_LOCK_CYCLES = 8'hc8;
  localparam int POST_DEPTH = 8;
  localparam int RD_PIPE_W = 16;
  // ---------------------------------------------------------------
  // APB map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_MAIN = 8'h00;
  localparam logic [7:0] ADDR_EXT = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_LOAD = 8'h0c;
  localparam int LD_BANK_LO = 16;
  localparam int ST_TEST = 0;
  localparam int ST_DLL_EN = 1;
  localparam int ST_LOCKED = 2;
  localparam int ST_ILLEGAL = 3;
  localparam int ST_EARLY = 4;
endpackage : ddr2_cfg_pkg

/* hw/burst_order.sv */
// Column offset within a burst block for one beat
module burst_order (
  // Burst setup
  input wire logic [2:0] start,
  input wire logic eight,
  input wire logic interleave,
  // Beat
  input wire logic [2:0] beat,
  output logic [2:0] offset
);
  logic [2:0] seq_sum;
  logic [2:0] ilv;
  logic [2:0] raw;
  assign seq_sum = start + beat;
  assign ilv = start ^ beat;
  assign raw = interleave ? ilv : seq_sum;
  // Four-beat bursts keep bit 2 of the start column
  assign offset = eight ? raw : {start[2], raw[1:0]};
endmodule : burst_order

/* hw/ddr2_mode_register_decode.sv */
// DDR2 main and extended configuration words with their decoded behaviour
//
// Local design decisions: the APB register port and the register addresses.
module ddr2_mode_register_decode (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Command pins
  input wire logic load_config_command,
  input wire ddr2_cfg_pkg::load_cmd_t load_cmd,
  input wire logic read_cmd,
  input wire logic write_cmd,
  input wire logic [ddr2_cfg_pkg::COL_W-1:0] cmd_column,
  input wire logic write_ap_last,
  input wire logic self_refresh_entry,
  input wire logic self_refresh_exit,
  input wire logic active_power_down,
  input wire logic precharge_power_down,
  // Burst and timing outputs
  output logic [ddr2_cfg_pkg::COL_W-1:0] burst_column,
  output logic burst_active,
  output logic burst_write,
  output logic read_data_start,
  output logic precharge_now,
  // DLL and power-down
  output logic dll_reset_pulse,
  output logic dll_enabled,
  output logic dll_locked,
  output logic dll_frozen,
  output logic fast_exit,
  // Output stage settings
  output logic drive_reduced,
  output logic strobe_comp_en,
  output logic read_strobe_en,
  output logic read_strobe_comp_en,
  // Decoded fields
  output logic test_mode,
  output logic [2:0] column_latency,
  output logic [2:0] additive_latency,
  output logic burst_beats_eight,
  output logic cfg_illegal
);
  localparam int OW = ddr2_cfg_pkg::OP_W;
  localparam int CW = ddr2_cfg_pkg::COL_W;
  localparam int PD = ddr2_cfg_pkg::POST_DEPTH;
  localparam int RW = ddr2_cfg_pkg::RD_PIPE_W;

  logic [OW-1:0] main_config_word_reg;
  logic [OW-1:0] extended_config_word_reg;
  logic test_mode_reg;
  logic in_self_refresh_reg;
  logic dll_reset_reg;
  logic [7:0] lock_cnt_reg;
  logic [7:0] lock_cnt_next;
  logic early_read_reg;
  logic [3:0] wr_cnt_reg;
  logic [3:0] wr_cnt_next;
  logic precharge_reg;
  logic [RW-1:0] rd_pipe_reg;
  ddr2_cfg_pkg::posted_t post_reg [PD];
  ddr2_cfg_pkg::posted_t post_in;
  ddr2_cfg_pkg::posted_t exec_cmd;
  logic [CW-1:0] bstart_reg;
  logic [2:0] beat_reg;
  logic bactive_reg;
  logic bwrite_reg;
  logic [2:0] boffset;
  logic [2:0] last_beat;
  logic [31:0] prdata_reg;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  logic apb_setup;
  logic apb_wr;
  logic hit_main;
  logic hit_ext;
  logic hit_status;
  logic hit_load;
  logic mapped;
  logic bus_load;
  logic early_clear;
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;
  assign hit_main = paddr == ddr2_cfg_pkg::ADDR_MAIN;
  assign hit_ext = paddr == ddr2_cfg_pkg::ADDR_EXT;
  assign hit_status = paddr == ddr2_cfg_pkg::ADDR_STATUS;
  assign hit_load = paddr == ddr2_cfg_pkg::ADDR_LOAD;
  assign mapped = pwrite ? (hit_load || hit_status) : (hit_main || hit_ext || hit_status);
  assign bus_load = apb_wr && hit_load;
  assign early_clear = apb_wr && hit_status && pwdata[ddr2_cfg_pkg::ST_EARLY];
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_reg;

  // ---------------------------------------------------------------
  // Load command decode
  // ---------------------------------------------------------------
  logic ld_any;
  ddr2_cfg_pkg::load_cmd_t ld;
  logic ld_main;
  logic ld_ext;
  logic ld_test;
  logic ld_normal;
  assign ld_any = load_config_command || bus_load;
  assign ld = load_config_command ? load_cmd
            : {pwdata[ddr2_cfg_pkg::LD_BANK_LO +: 3], pwdata[OW-1:0]};
  assign ld_main = ld_any && ld.bank == ddr2_cfg_pkg::BANK_MAIN;
  assign ld_ext = ld_any && ld.bank == ddr2_cfg_pkg::BANK_EXT;
  assign ld_test = ld_main && ld.op[ddr2_cfg_pkg::M_TEST];
  assign ld_normal = ld_main && !ld.op[ddr2_cfg_pkg::M_TEST];

  // ---------------------------------------------------------------
  // Field decode
  // ---------------------------------------------------------------
  logic [2:0] bl_code;
  logic [2:0] wr_code;
  logic [3:0] read_latency;
  logic [3:0] wr_clocks;
  logic cl_bad;
  logic wr_bad;
  logic bl_bad;
  logic al_bad;
  assign bl_code = main_config_word_reg[ddr2_cfg_pkg::M_BL_HI:ddr2_cfg_pkg::M_BL_LO];
  assign burst_beats_eight = bl_code == ddr2_cfg_pkg::BL_CODE_8;
  assign column_latency = main_config_word_reg[ddr2_cfg_pkg::M_CL_HI:ddr2_cfg_pkg::M_CL_LO];
  assign cl_bad = column_latency < ddr2_cfg_pkg::CL_MIN;
  assign wr_code = main_config_word_reg[ddr2_cfg_pkg::M_WR_HI:ddr2_cfg_pkg::M_WR_LO];
  assign wr_bad = wr_code < ddr2_cfg_pkg::WR_CODE_MIN || wr_code > ddr2_cfg_pkg::WR_CODE_MAX;
  assign wr_clocks = {1'b0, wr_code} + 4'h1;
  assign bl_bad = bl_code != ddr2_cfg_pkg::BL_CODE_4 && !burst_beats_eight;
  assign additive_latency =
    extended_config_word_reg[ddr2_cfg_pkg::E_AL_HI:ddr2_cfg_pkg::E_AL_LO];
  assign al_bad = additive_latency > ddr2_cfg_pkg::AL_MAX;
  assign cfg_illegal = cl_bad || wr_bad || bl_bad || al_bad;
  assign read_latency = {1'b0, column_latency} + {1'b0, additive_latency};
  assign test_mode = test_mode_reg;

  // ---------------------------------------------------------------
  // Output stage and power-down
  // ---------------------------------------------------------------
  assign drive_reduced = extended_config_word_reg[ddr2_cfg_pkg::E_DRV];
  assign strobe_comp_en = !extended_config_word_reg[ddr2_cfg_pkg::E_STB_DIS];
  assign read_strobe_en = extended_config_word_reg[ddr2_cfg_pkg::E_RSTB];
  assign read_strobe_comp_en = read_strobe_en && strobe_comp_en;
  assign fast_exit = !main_config_word_reg[ddr2_cfg_pkg::M_PD];
  // Freeze only in active power-down; precharge power-down ignores style
  assign dll_frozen = active_power_down && !fast_exit;
  assign dll_enabled = !extended_config_word_reg[ddr2_cfg_pkg::E_DLL_DIS]
                       && !in_self_refresh_reg;
  assign dll_locked = dll_enabled && lock_cnt_reg == 8'h00;
  assign dll_reset_pulse = dll_reset_reg;

  // ---------------------------------------------------------------
  // Configuration words
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      main_config_word_reg <= '0;
      extended_config_word_reg <= '0;
      test_mode_reg <= 1'b0;
    end else begin
      if (ld_normal) begin
        // Reset bit is never stored, so it always reads back zero
        main_config_word_reg <= ld.op & ~(OW'(1) << ddr2_cfg_pkg::M_DLL_RST);
      end
      if (ld_main) begin
        test_mode_reg <= ld_test;
      end
      if (ld_ext) begin
        extended_config_word_reg <= ld.op;
      end
    end
  end

  // ---------------------------------------------------------------
  // DLL reset, lock wait and self refresh
  // ---------------------------------------------------------------
  assign lock_cnt_next = dll_reset_reg ? ddr2_cfg_pkg::DLL_LOCK_CYCLES
                       : (lock_cnt_reg != 8'h00 ? lock_cnt_reg - 8'h01 : lock_cnt_reg);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dll_reset_reg <= 1'b0;
      in_self_refresh_reg <= 1'b0;
      lock_cnt_reg <= ddr2_cfg_pkg::DLL_LOCK_CYCLES;
      early_read_reg <= 1'b0;
    end else begin
      dll_reset_reg <= (ld_normal && ld.op[ddr2_cfg_pkg::M_DLL_RST])
                       || (self_refresh_exit && in_self_refresh_reg);
      if (self_refresh_entry) begin
        in_self_refresh_reg <= 1'b1;
      end else if (self_refresh_exit) begin
        in_self_refresh_reg <= 1'b0;
      end
      lock_cnt_reg <= lock_cnt_next;
      // Set wins over a software clear in the same cycle
      if (read_cmd && !dll_locked) begin
        early_read_reg <= 1'b1;
      end else if (early_clear) begin
        early_read_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read latency and posted commands
  // ---------------------------------------------------------------
  assign read_data_start = read_latency != 4'h0 && rd_pipe_reg[read_latency - 4'h1];
  assign post_in = '{valid: read_cmd || write_cmd, write: write_cmd, col: cmd_column};
  assign exec_cmd = additive_latency == 3'h0 ? post_in
                  : post_reg[additive_latency - 3'h1];
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_pipe_reg <= '0;
      for (int i = 0; i < PD; i++) begin
        post_reg[i] <= '0;
      end
    end else begin
      rd_pipe_reg <= {rd_pipe_reg[RW-2:0], read_cmd};
      post_reg[0] <= post_in;
      for (int i = 1; i < PD; i++) begin
        post_reg[i] <= post_reg[i-1];
      end
    end
  end

  // ---------------------------------------------------------------
  // Burst column sequencing
  // ---------------------------------------------------------------
  burst_order u_order (
    .start(bstart_reg[2:0]),
    .eight(burst_beats_eight),
    .interleave(main_config_word_reg[ddr2_cfg_pkg::M_BT]),
    .beat(beat_reg),
    .offset(boffset)
  );
  assign last_beat = burst_beats_eight ? 3'h7 : 3'h3;
  // Block bits stay from the start column, so the burst wraps inside it
  assign burst_column = {bstart_reg[CW-1:3], boffset};
  assign burst_active = bactive_reg;
  assign burst_write = bwrite_reg;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bstart_reg <= '0;
      beat_reg <= 3'h0;
      bactive_reg <= 1'b0;
      bwrite_reg <= 1'b0;
    end else if (exec_cmd.valid) begin
      bstart_reg <= exec_cmd.col;
      beat_reg <= 3'h0;
      bactive_reg <= 1'b1;
      bwrite_reg <= exec_cmd.write;
    end else if (bactive_reg) begin
      beat_reg <= beat_reg + 3'h1;
      bactive_reg <= beat_reg != last_beat;
    end
  end

  // ---------------------------------------------------------------
  // Write recovery before auto precharge
  // ---------------------------------------------------------------
  assign wr_cnt_next = write_ap_last ? wr_clocks
                     : (wr_cnt_reg != 4'h0 ? wr_cnt_reg - 4'h1 : 4'h0);
  assign precharge_now = precharge_reg;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_cnt_reg <= 4'h0;
      precharge_reg <= 1'b0;
    end else begin
      wr_cnt_reg <= wr_cnt_next;
      precharge_reg <= !write_ap_last && wr_cnt_reg == 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // APB read data
  // ---------------------------------------------------------------
  logic [31:0] status_word;
  logic [31:0] rd_mux;
  always_comb begin
    status_word = '0;
    status_word[ddr2_cfg_pkg::ST_TEST] = test_mode_reg;
    status_word[ddr2_cfg_pkg::ST_DLL_EN] = dll_enabled;
    status_word[ddr2_cfg_pkg::ST_LOCKED] = dll_locked;
    status_word[ddr2_cfg_pkg::ST_ILLEGAL] = cfg_illegal;
    status_word[ddr2_cfg_pkg::ST_EARLY] = early_read_reg;
  end
  assign rd_mux = hit_main ? 32'(main_config_word_reg)
                : hit_ext ? 32'(extended_config_word_reg)
                : hit_status ? status_word : 32'h0000_0000;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prdata_reg <= 32'h0000_0000;
    end else if (apb_setup) begin
      prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_test_load;
    ld_test;
  endsequence
  sequence s_words_held;
    $stable(main_config_word_reg) ##0 test_mode_reg;
  endsequence
  a_test_mode_hold: assert property (s_test_load |=> s_words_held)
    else $error("test-mode load changed the main word");
  a_dll_reset_clear: assert property (
    ld_normal && ld.op[ddr2_cfg_pkg::M_DLL_RST]
    |=> dll_reset_pulse && !main_config_word_reg[ddr2_cfg_pkg::M_DLL_RST]
    ##1 !dll_reset_pulse)
    else $error("dll reset not started or bit not cleared");
  a_read_cl3: assert property (
    read_cmd && additive_latency == 3'h0 && column_latency == 3'h3
    && $stable(read_latency) |-> ##3 read_data_start)
    else $error("first read data not at edge n plus 3");
  a_posted_hold: assert property (
    read_cmd && additive_latency == 3'h2 |-> ##3 bactive_reg && beat_reg == 3'h0
    && bstart_reg == $past(cmd_column, 3))
    else $error("posted read not executed after additive latency");
  a_wr_recovery: assert property (
    write_ap_last && wr_code == 3'h1 ##1 !write_ap_last [*2]
    |=> precharge_now)
    else $error("auto precharge not two clocks after last data");
  a_sr_dll_off: assert property (
    self_refresh_entry |=> !dll_enabled)
    else $error("dll still enabled in self refresh");
  a_sr_exit_reset: assert property (
    self_refresh_exit && in_self_refresh_reg |=> dll_reset_pulse ##1 !dll_locked)
    else $error("self-refresh exit did not reset dll");
  a_pd_style: assert property (
    precharge_power_down && !active_power_down |-> !dll_frozen)
    else $error("precharge power-down froze the dll");
  a_strobe_pair: assert property (
    read_strobe_comp_en == (extended_config_word_reg[ddr2_cfg_pkg::E_RSTB]
    && !extended_config_word_reg[ddr2_cfg_pkg::E_STB_DIS]))
    else $error("read strobe complement enable wrong");
  a_burst_wrap: assert property (
    bactive_reg |-> burst_column[CW-1:3] == bstart_reg[CW-1:3]
    && (burst_beats_eight || burst_column[2] == bstart_reg[2]))
    else $error("burst left its column block");
  a_ext_hold: assert property (
    !ld_ext |=> $stable(extended_config_word_reg))
    else $error("extended word changed without a load");
endmodule : ddr2_mode_register_decode

/* tb/ctrl_model.sv */
// Controller model driving load, column and self-refresh commands
module ctrl_model #(
  parameter int MODE_SET_DELAY = 2
) (
  // Clock
  input wire logic clk,
  // Command pins
  output logic load_config_command,
  output ddr2_cfg_pkg::load_cmd_t load_cmd,
  output logic read_cmd,
  output logic write_cmd,
  output logic [ddr2_cfg_pkg::COL_W-1:0] cmd_column,
  output logic write_ap_last,
  output logic self_refresh_entry,
  output logic self_refresh_exit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] main_shadow = 14'h0000;
  time rst_at = 0;
  initial begin
    {load_config_command, read_cmd, write_cmd, write_ap_last} = 4'h0;
    {self_refresh_entry, self_refresh_exit} = 2'h0;
    load_cmd = '0;
    cmd_column = '0;
  end
  // Full-word load; lines show the inverse once released
  task automatic load(input logic [2:0] bank, input logic [13:0] op, input logic test);
    ddr2_cfg_pkg::load_cmd_t c;
    c.bank = {1'b0, bank[1:0]};
    c.op = op;
    if (!test) c.op[7] = 1'b0;
    if (c.bank == 3'h1) c.op[13] = 1'b0;
    if (c.bank == 3'h0 && op[11:9] inside {3'h0, 3'h7}) c.op[11:9] = 3'h1;
    @(posedge clk);
    load_config_command <= 1'b1;
    load_cmd <= c;
    @(posedge clk);
    load_config_command <= 1'b0;
    load_cmd <= ~c;
    if (c.bank == 3'h0 && !c.op[7]) main_shadow = c.op & 14'h3eff;
    if (c.bank == 3'h0 && c.op[8]) rst_at = $time;
    repeat (MODE_SET_DELAY) @(posedge clk);
    if (c.bank == 3'h1 && !c.op[0]) load(3'h0, main_shadow | 14'h0100, 1'b0);
  endtask : load
  task automatic column(input logic wr, input logic [9:0] col);
    if (!wr) while ($time - rst_at < 200 * 20) @(posedge clk);
    @(posedge clk);
    read_cmd <= !wr;
    write_cmd <= wr;
    cmd_column <= col;
    @(posedge clk);
    read_cmd <= 1'b0;
    write_cmd <= 1'b0;
    cmd_column <= ~col;
  endtask : column
  // 0: last write data with precharge, 1: self-refresh entry, 2: exit
  task automatic strobe(input int sel);
    @(posedge clk);
    {self_refresh_exit, self_refresh_entry, write_ap_last} <= 3'(1 << sel);
    @(posedge clk);
    {self_refresh_exit, self_refresh_entry, write_ap_last} <= 3'h0;
    if (sel == 2) rst_at = $time;
  endtask : strobe
endmodule : ctrl_model

/* tb/ddr2_mode_register_decode_tb_top.sv */
// Self-checking bench for the configuration-word decoder
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %0t mismatch %h vs %h", $time, g, e); end end
module ddr2_mode_register_decode_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b, psel, penable, pwrite, pready, pslverr, err, eight, ilv;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, w;
  logic load_config_command, read_cmd, write_cmd, write_ap_last;
  logic self_refresh_entry, self_refresh_exit, active_power_down, precharge_power_down;
  ddr2_cfg_pkg::load_cmd_t load_cmd;
  logic [9:0] cmd_column, burst_column;
  logic burst_active, burst_write, read_data_start, precharge_now, dll_reset_pulse;
  logic dll_enabled, dll_locked, dll_frozen, fast_exit, drive_reduced, strobe_comp_en;
  logic read_strobe_en, read_strobe_comp_en, test_mode, burst_beats_eight, cfg_illegal;
  logic [2:0] column_latency, additive_latency;
  int miscompares = 0;
  int tests_run = 0;
  int k;
  always #10 clk = ~clk;
  ddr2_mode_register_decode u_ddr2_mode_register_decode (
    .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .load_config_command, .load_cmd, .read_cmd, .write_cmd, .cmd_column, .write_ap_last,
    .self_refresh_entry, .self_refresh_exit, .active_power_down, .precharge_power_down,
    .burst_column, .burst_active, .burst_write, .read_data_start, .precharge_now,
    .dll_reset_pulse, .dll_enabled, .dll_locked, .dll_frozen, .fast_exit, .drive_reduced,
    .strobe_comp_en, .read_strobe_en, .read_strobe_comp_en, .test_mode, .column_latency,
    .additive_latency, .burst_beats_eight, .cfg_illegal);
  ctrl_model u_ctrl_model (.clk, .load_config_command, .load_cmd, .read_cmd, .write_cmd,
    .cmd_column, .write_ap_last, .self_refresh_entry, .self_refresh_exit);
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (int i = 0; i <= 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
      if (i == 20) begin
        miscompares++;
        results();
      end
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [9:0] exp_col(input logic [9:0] c, input int b);
    logic [2:0] o;
    o = ilv ? c[2:0] ^ 3'(b) : c[2:0] + 3'(b);
    if (!eight) o[2] = c[2];
    return {c[9:3], o};
  endfunction : exp_col
  task automatic main(input logic pd, input logic [2:0] wr, input logic [2:0] cl,
                      input logic bt, input logic e8);
    eight = e8;
    ilv = bt;
    u_ctrl_model.load(3'h0, {1'b0, pd, wr, 2'h0, cl, bt,
      e8 ? ddr2_cfg_pkg::BL_CODE_8 : ddr2_cfg_pkg::BL_CODE_4}, 1'b0);
    #1;
    `CHK(column_latency, cl)
    `CHK(burst_beats_eight, e8)
    `CHK(cfg_illegal, cl < 3'h3)
  endtask : main
  task automatic burst(input logic wr, input logic [9:0] col, input int rl);
    int b = 0;
    int rds = -1;
    u_ctrl_model.column(wr, col);
    for (int j = 0; j < 40; j++) begin
      #1;
      if (burst_active === 1'b1) begin
        if (b < 8) `CHK(burst_column, exp_col(col, b))
        `CHK(burst_write, wr)
        b++;
      end
      if (read_data_start === 1'b1 && rds < 0) rds = j;
      @(posedge clk);
    end
    `CHK(b, eight ? 8 : 4)
    if (!wr) `CHK(rds, rl - 1)
  endtask : burst
  task automatic pd(input logic a, input logic p);
    @(posedge clk);
    active_power_down <= a;
    precharge_power_down <= p;
    @(posedge clk);
    #1;
  endtask : pd
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    {rst_b, psel, penable, pwrite, active_power_down, precharge_power_down} = 6'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, ddr2_cfg_pkg::ADDR_STATUS, 32'h0);
    `CHK(rd, 32'h0000_000a)
    `CHK(err, 1'b0)
    apb(1'b0, ddr2_cfg_pkg::ADDR_LOAD, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b1, ddr2_cfg_pkg::ADDR_LOAD, 32'h0000_0132);
    apb(1'b0, ddr2_cfg_pkg::ADDR_MAIN, 32'h0);
    `CHK(rd, 32'h0000_0032)
    repeat (195) @(posedge clk);
    `CHK(dll_locked, 1'b0)
    repeat (10) @(posedge clk);
    `CHK(dll_locked, 1'b1)
    $display("register access and dll reset done");
    for (int i = 0; i < 5; i++) begin
      main(1'b0, 3'h1, 3'(3 + i), i[0], i[1] | i[2]);
      burst(1'b0, 10'h2a5, 3 + i);
    end
    main(1'b0, 3'h1, 3'h2, 1'b0, 1'b0);
    burst(1'b1, 10'h3fe, 0);
    $display("burst order and latency done");
    main(1'b0, 3'h1, 3'h4, 1'b0, 1'b0);
    u_ctrl_model.load(3'h1, 14'h0010, 1'b0);
    `CHK(additive_latency, 3'h2)
    apb(1'b0, ddr2_cfg_pkg::ADDR_EXT, 32'h0);
    `CHK(rd, 32'h0000_0010)
    apb(1'b0, ddr2_cfg_pkg::ADDR_MAIN, 32'h0);
    `CHK(rd, 32'(u_ctrl_model.main_shadow))
    burst(1'b0, 10'h001, 6);
    for (int i = 0; i < 4; i++) begin
      u_ctrl_model.load(3'h1, {2'h0, i[1], i[0], 8'h00, i[0] ^ i[1], 1'b1}, 1'b0);
      `CHK(drive_reduced, i[0] ^ i[1])
      `CHK(strobe_comp_en, !i[0])
      `CHK(read_strobe_en, i[1])
      `CHK(read_strobe_comp_en, i[1] & !i[0])
      `CHK(dll_enabled, 1'b0)
    end
    u_ctrl_model.load(3'h1, 14'h0000, 1'b0);
    `CHK(dll_enabled, 1'b1)
    $display("extended word done");
    main(1'b1, 3'h1, 3'h3, 1'b0, 1'b0);
    pd(1'b1, 1'b0);
    `CHK(dll_frozen, 1'b1)
    `CHK(fast_exit, 1'b0)
    pd(1'b0, 1'b1);
    `CHK(dll_frozen, 1'b0)
    main(1'b0, 3'h1, 3'h3, 1'b0, 1'b0);
    pd(1'b1, 1'b0);
    `CHK(fast_exit, 1'b1)
    `CHK(dll_frozen, 1'b0)
    pd(1'b0, 1'b0);
    $display("power-down style done");
    for (int i = 1; i < 7; i += 5) begin
      main(1'b0, 3'(i), 3'h3, 1'b0, 1'b0);
      u_ctrl_model.strobe(0);
      k = -1;
      for (int j = 0; j < 20; j++) begin
        #1;
        if (precharge_now === 1'b1 && k < 0) k = j;
        @(posedge clk);
      end
      `CHK(k, i + 1)
    end
    $display("write recovery done");
    u_ctrl_model.strobe(1);
    #1;
    `CHK(dll_enabled, 1'b0)
    u_ctrl_model.strobe(2);
    #1;
    `CHK(dll_reset_pulse, 1'b1)
    `CHK(dll_enabled, 1'b1)
    $display("self refresh done");
    apb(1'b0, ddr2_cfg_pkg::ADDR_MAIN, 32'h0);
    w = rd;
    u_ctrl_model.load(3'h0, 14'h00d2, 1'b1);
    `CHK(test_mode, 1'b1)
    apb(1'b0, ddr2_cfg_pkg::ADDR_MAIN, 32'h0);
    `CHK(rd, w)
    apb(1'b0, ddr2_cfg_pkg::ADDR_STATUS, 32'h0);
    `CHK(rd, 32'h0000_0003)
    $display("test state done");
    results();
  end
  initial begin
    repeat (50000) @(posedge clk);
    miscompares++;
    results();
  end
endmodule : ddr2_mode_register_decode_tb_top
